// ### verilog/jbs_tap.sv
// Test access port controller with instruction, bypass, identification and boundary paths.
`timescale 1ns/1ps
module jbs_tap #(
	parameter int N_IN = jbs_pkg::JBS_N_IN,
	parameter int N_OUT = jbs_pkg::JBS_N_OUT,
	parameter logic [3:0] ID_VERSION = 4'h1, // Arbitrary value.
	parameter logic [15:0] ID_PART = 16'h1234, // Arbitrary value.
	parameter logic [10:0] ID_MFR = 11'h055 // Arbitrary value.
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst_n,
	output logic tdo,
	output logic tdo_oe,
	input wire logic [N_IN-1:0] pin_in,
	output logic [N_IN-1:0] core_in,
	input wire logic [N_OUT-1:0] core_out,
	output logic [N_OUT-1:0] pin_out,
	output logic factory_test
);
	import jbs_pkg::*;

	localparam int LEN = N_IN + N_OUT;
	localparam logic [JBS_ID_LEN-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MFR, 1'b1}; // R11 R16

	jbs_pins_s pins_raw;
	jbs_pins_s pins_s;
	logic [N_IN-1:0] pin_in_s;
	logic tck_d_r;
	logic rise;
	logic fall;
	logic trst_act;
	jbs_state_e state_r;
	jbs_state_e state_nxt;
	jbs_ir_t ir_r;
	jbs_ir_t ir_sr_r;
	logic bypass_r;
	logic [JBS_ID_LEN-1:0] id_sr_r;
	logic [LEN-1:0] bsr_sh;
	logic [LEN-1:0] bsr_upd;
	logic [LEN-1:0] bsr_cap;
	logic sel_id;
	logic sel_bsr;
	logic sel_bypass;
	logic extest_mode;
	logic intest_mode;
	logic dr_cap;
	logic dr_shift;
	logic dr_upd;
	logic shifting;
	logic tdo_bit;
	logic tdo_r;
	logic tdo_oe_r;
	logic [N_IN-1:0] core_in_r;
	logic [N_OUT-1:0] pin_out_r;
	logic factory_test_r;

	// All four test input pins come from the tester's domain, so each passes two flops.
	assign pins_raw.tck = tck; // R1
	assign pins_raw.tms = tms;
	assign pins_raw.tdi = tdi;
	assign pins_raw.trst_n = trst_n;

	jbs_sync #(
		.W($bits(jbs_pins_s)),
		.RST_VAL(JBS_PINS_RESET)
	) u_pin_sync (
		.clk(clk),
		.rst(rst),
		.d(pins_raw),
		.q(pins_s)
	);

	jbs_sync #(
		.W(N_IN),
		.RST_VAL('0)
	) u_in_sync (
		.clk(clk),
		.rst(rst),
		.d(pin_in),
		.q(pin_in_s)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			tck_d_r <= 1'b0;
		end else begin
			tck_d_r <= pins_s.tck;
		end
	end

	assign rise = pins_s.tck & ~tck_d_r;
	assign fall = ~pins_s.tck & tck_d_r;
	assign trst_act = ~pins_s.trst_n;

	// Standard sixteen-state walk under the test mode select level.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			JBS_TLR: state_nxt = pins_s.tms ? JBS_TLR : JBS_RTI;
			JBS_RTI: state_nxt = pins_s.tms ? JBS_SEL_DR : JBS_RTI;
			JBS_SEL_DR: state_nxt = pins_s.tms ? JBS_SEL_IR : JBS_CAP_DR;
			JBS_CAP_DR: state_nxt = pins_s.tms ? JBS_EXIT1_DR : JBS_SHIFT_DR;
			JBS_SHIFT_DR: state_nxt = pins_s.tms ? JBS_EXIT1_DR : JBS_SHIFT_DR;
			JBS_EXIT1_DR: state_nxt = pins_s.tms ? JBS_UPD_DR : JBS_PAUSE_DR;
			JBS_PAUSE_DR: state_nxt = pins_s.tms ? JBS_EXIT2_DR : JBS_PAUSE_DR;
			JBS_EXIT2_DR: state_nxt = pins_s.tms ? JBS_UPD_DR : JBS_SHIFT_DR;
			JBS_UPD_DR: state_nxt = pins_s.tms ? JBS_SEL_DR : JBS_RTI;
			JBS_SEL_IR: state_nxt = pins_s.tms ? JBS_TLR : JBS_CAP_IR;
			JBS_CAP_IR: state_nxt = pins_s.tms ? JBS_EXIT1_IR : JBS_SHIFT_IR;
			JBS_SHIFT_IR: state_nxt = pins_s.tms ? JBS_EXIT1_IR : JBS_SHIFT_IR;
			JBS_EXIT1_IR: state_nxt = pins_s.tms ? JBS_UPD_IR : JBS_PAUSE_IR;
			JBS_PAUSE_IR: state_nxt = pins_s.tms ? JBS_EXIT2_IR : JBS_PAUSE_IR;
			JBS_EXIT2_IR: state_nxt = pins_s.tms ? JBS_UPD_IR : JBS_SHIFT_IR;
			JBS_UPD_IR: state_nxt = pins_s.tms ? JBS_SEL_DR : JBS_RTI;
			default: state_nxt = JBS_TLR;
		endcase
	end

	// A low test reset needs no test clock edge; it wins over any pending move.
	always_ff @(posedge clk) begin
		if (rst || trst_act) begin
			state_r <= JBS_TLR; // R10
		end else if (rise) begin
			state_r <= state_nxt; // R15
		end
	end

	// Instruction register; the reset state leaves a non-intrusive instruction loaded.
	always_ff @(posedge clk) begin
		if (rst || trst_act || state_r == JBS_TLR) begin
			ir_r <= JBS_IR_RESET; // R9
			ir_sr_r <= JBS_IR_CAPTURE;
		end else begin
			if (rise && state_r == JBS_CAP_IR) begin
				ir_sr_r <= JBS_IR_CAPTURE;
			end else if (rise && state_r == JBS_SHIFT_IR) begin
				ir_sr_r <= {pins_s.tdi, ir_sr_r[JBS_IR_LEN-1:1]};
			end
			if (fall && state_r == JBS_UPD_IR) begin
				ir_r <= ir_sr_r; // R7
			end
		end
	end

	// Unknown opcodes fall back to the bypass path, as do CLAMP and the factory instruction.
	assign sel_id = (ir_r == JBS_OP_IDCODE); // R12
	assign sel_bsr = (ir_r == JBS_OP_EXTEST) || (ir_r == JBS_OP_SAMPLE) || (ir_r == JBS_OP_INTEST); // R3 R4
	assign sel_bypass = ~sel_id & ~sel_bsr; // R2 R6
	assign extest_mode = (ir_r == JBS_OP_EXTEST) || (ir_r == JBS_OP_CLAMP); // R3 R6
	assign intest_mode = (ir_r == JBS_OP_INTEST); // R7

	assign dr_cap = rise && state_r == JBS_CAP_DR;
	assign dr_shift = rise && state_r == JBS_SHIFT_DR;
	assign dr_upd = fall && state_r == JBS_UPD_DR;

	always_ff @(posedge clk) begin
		if (rst) begin
			bypass_r <= 1'b0;
			id_sr_r <= '0;
		end else begin
			if (dr_cap && sel_bypass) begin
				bypass_r <= 1'b0; // R2
			end else if (dr_shift && sel_bypass) begin
				bypass_r <= pins_s.tdi; // R2
			end
			if (dr_cap && sel_id) begin
				id_sr_r <= ID_VALUE; // R13
			end else if (dr_shift && sel_id) begin
				id_sr_r <= {pins_s.tdi, id_sr_r[JBS_ID_LEN-1:1]}; // R14
			end
		end
	end

	// Input cells see the pins, output cells see what the core wants to drive.
	assign bsr_cap = {core_out, pin_in_s}; // R4

	jbs_bsr #(
		.LEN(LEN)
	) u_bsr (
		.clk(clk),
		.rst(rst),
		.cap_en(dr_cap && sel_bsr),
		.shift_en(dr_shift && sel_bsr),
		.upd_en(dr_upd && sel_bsr), // R5
		.cap_data(bsr_cap),
		.tdi(pins_s.tdi),
		.sh_q(bsr_sh),
		.upd_q(bsr_upd)
	);

	assign shifting = (state_r == JBS_SHIFT_DR) || (state_r == JBS_SHIFT_IR);
	assign tdo_bit = (state_r == JBS_SHIFT_IR) ? ir_sr_r[0] :
		sel_id ? id_sr_r[0] :
		sel_bsr ? bsr_sh[0] : bypass_r;

	// Output changes on the falling test clock so the tester samples a settled bit.
	always_ff @(posedge clk) begin
		if (rst || trst_act) begin
			tdo_r <= 1'b0;
			tdo_oe_r <= 1'b0;
		end else if (fall) begin
			tdo_r <= tdo_bit; // R15
			tdo_oe_r <= shifting; // R15
		end
	end

	// Pin and core paths are registered; functional data sees one extra clock of delay.
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_out_r <= '0;
			core_in_r <= '0;
			factory_test_r <= 1'b0;
		end else begin
			pin_out_r <= extest_mode ? bsr_upd[LEN-1:N_IN] : core_out; // R3 R4 R6
			core_in_r <= intest_mode ? bsr_upd[N_IN-1:0] : pin_in_s; // R7
			factory_test_r <= (ir_r == JBS_OP_PRIVATE_FACTORY_TEST); // R7
		end
	end

	assign tdo = tdo_r;
	assign tdo_oe = tdo_oe_r;
	assign pin_out = pin_out_r;
	assign core_in = core_in_r;
	assign factory_test = factory_test_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_trst_forces_reset: assert property ( // R10
		trst_act |=> state_r == JBS_TLR) else $error("Test reset did not force the reset state.");

	a_reset_loads_idcode: assert property ( // R9
		(state_r == JBS_TLR) |=> ir_r == JBS_OP_IDCODE) else $error("Reset state left a wrong instruction.");

	a_fsm_leaves_reset: assert property ( // R15
		(rise && !trst_act && state_r == JBS_TLR && !pins_s.tms) |=> state_r == JBS_RTI)
		else $error("Controller did not move to idle.");

	a_bypass_capture_zero: assert property ( // R2
		(dr_cap && sel_bypass) |=> !bypass_r) else $error("Bypass bit did not capture zero.");

	a_id_capture_code: assert property ( // R13
		(dr_cap && sel_id) |=> (id_sr_r == ID_VALUE) && id_sr_r[0]) else $error("Identification capture wrong.");

	a_id_lsb_first: assert property ( // R14
		(fall && !trst_act && state_r == JBS_SHIFT_DR && sel_id) |=> tdo_r == $past(id_sr_r[0]) && tdo_oe_r)
		else $error("Identification bit 0 not driven first.");

	a_tdo_off_idle: assert property ( // R15
		(fall && !shifting) |=> !tdo_oe_r) else $error("Data output enabled outside shift.");

	a_clamp_holds_pins: assert property ( // R6
		($past(ir_r) == JBS_OP_CLAMP) |-> pin_out_r == $past(bsr_upd[LEN-1:N_IN]))
		else $error("Clamp did not drive pins from update stage.");

	a_sample_no_disturb: assert property ( // R4
		($past(ir_r) == JBS_OP_SAMPLE) |-> pin_out_r == $past(core_out))
		else $error("Sample disturbed the pins.");

	a_extest_drives_pins: assert property ( // R3
		(ir_r == JBS_OP_EXTEST) |=> pin_out_r == $past(bsr_upd[LEN-1:N_IN]))
		else $error("External test did not drive pins.");

	// The bench sees these paths only through the pins, so the internal steps are watched here.
	a_trst_clears_oe: assert property ( // R10
		trst_act |=> !tdo_oe_r && !tdo_r)
		else $error("Test reset left the data output enabled.");

	a_bypass_shift_bit: assert property ( // R2
		(dr_shift && sel_bypass) |=> bypass_r == $past(pins_s.tdi))
		else $error("Bypass bit did not take the data input.");

	a_bypass_on_output: assert property ( // R2
		(fall && !trst_act && state_r == JBS_SHIFT_DR && sel_bypass) |=> tdo_r == $past(bypass_r) && tdo_oe_r)
		else $error("Bypass bit not driven on the data output.");

	a_id_shift_order: assert property ( // R14
		(dr_shift && sel_id) |=> id_sr_r == {$past(pins_s.tdi), $past(id_sr_r[JBS_ID_LEN-1:1])})
		else $error("Identification register shifted the wrong way.");

	a_ir_capture_value: assert property ( // R15
		(rise && state_r == JBS_CAP_IR) |=> ir_sr_r == JBS_IR_CAPTURE)
		else $error("Instruction capture value wrong.");

	a_ir_update_load: assert property ( // R7
		(fall && !trst_act && state_r == JBS_UPD_IR) |=> ir_r == $past(ir_sr_r))
		else $error("Instruction register did not load the shifted opcode.");

	a_factory_flag: assert property ( // R7
		(ir_r == JBS_OP_PRIVATE_FACTORY_TEST) |=> factory_test_r)
		else $error("Factory test flag not raised.");

	a_intest_drives_core: assert property ( // R7
		(ir_r == JBS_OP_INTEST) |=> core_in_r == $past(bsr_upd[N_IN-1:0]))
		else $error("Internal test did not drive the core inputs.");

	a_sample_captures_pins: assert property ( // R4
		(dr_cap && ir_r == JBS_OP_SAMPLE) |=> bsr_sh == $past(bsr_cap))
		else $error("Sample did not capture the pin levels.");

	a_idle_not_intrusive: assert property ( // R9
		(ir_r == JBS_OP_IDCODE) |=> pin_out_r == $past(core_out) && core_in_r == $past(pin_in_s))
		else $error("Identification instruction disturbed the pins.");

endmodule // jbs_tap

// ### verilog/jbs_pkg.sv
// Package for the boundary scan test access port: states, opcodes, sizes and reset values.
// Contract
// R1: Five dedicated test pins reach scan logic.
// R2: BYPASS puts one-bit register between data pins.
// R3: EXTEST drives and observes pins from scan register.
// R4: SAMPLE captures inputs without disturbing pins.
// R5: SAMPLE allows preload into latched update stages.
// R6: CLAMP selects bypass, pins driven from register.
// R7: INTEST and private factory instruction are accepted.
// R8: Tester holds reset state in functional mode.
// R9: Reset state loads IDCODE into instruction register.
// R10: Low test reset forces reset state without clock.
// R11: Identification register is 32 bits with fields.
// R12: IDCODE puts identification register on serial path.
// R13: Code captured in capture state, shifted out later.
// R14: Bit 0 nearest output, shifted out first.
// R15: Sixteen-state controller; output changes on falling edges.
// R16: Identification code least significant bit is one.
package jbs_pkg;

	localparam int JBS_IR_LEN = 4;
	localparam int JBS_ID_LEN = 32;
	localparam int JBS_N_IN = 8;
	localparam int JBS_N_OUT = 8;
	localparam int JBS_SYNC_STAGES = 2;

	typedef logic [JBS_IR_LEN-1:0] jbs_ir_t;

	localparam jbs_ir_t JBS_OP_EXTEST = 4'h0;
	localparam jbs_ir_t JBS_OP_SAMPLE = 4'h1;
	localparam jbs_ir_t JBS_OP_IDCODE = 4'h2;
	localparam jbs_ir_t JBS_OP_CLAMP = 4'h3;
	localparam jbs_ir_t JBS_OP_INTEST = 4'h4;
	localparam jbs_ir_t JBS_OP_PRIVATE_FACTORY_TEST = 4'h8;
	localparam jbs_ir_t JBS_OP_BYPASS = 4'hf;
	localparam jbs_ir_t JBS_IR_CAPTURE = 4'h1;
	localparam jbs_ir_t JBS_IR_RESET = JBS_OP_IDCODE;

	typedef enum logic [3:0] {
		JBS_TLR = 4'h0,
		JBS_RTI = 4'h1,
		JBS_SEL_DR = 4'h2,
		JBS_CAP_DR = 4'h3,
		JBS_SHIFT_DR = 4'h4,
		JBS_EXIT1_DR = 4'h5,
		JBS_PAUSE_DR = 4'h6,
		JBS_EXIT2_DR = 4'h7,
		JBS_UPD_DR = 4'h8,
		JBS_SEL_IR = 4'h9,
		JBS_CAP_IR = 4'ha,
		JBS_SHIFT_IR = 4'hb,
		JBS_EXIT1_IR = 4'hc,
		JBS_PAUSE_IR = 4'hd,
		JBS_EXIT2_IR = 4'he,
		JBS_UPD_IR = 4'hf
	} jbs_state_e;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic trst_n;
	} jbs_pins_s;

	localparam jbs_pins_s JBS_PINS_RESET = 4'h0;

endpackage

// ### verilog/jbs_sync.sv
// Two-flop synchroniser for a group of levels arriving from outside the clock domain.
`timescale 1ns/1ps
module jbs_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	import jbs_pkg::*;

	logic [W-1:0] meta_r;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // jbs_sync

// ### verilog/jbs_bsr.sv
// Boundary scan register: capture and shift stage per cell plus a latched update stage.
`timescale 1ns/1ps
module jbs_bsr #(
	parameter int LEN = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cap_en,
	input wire logic shift_en,
	input wire logic upd_en,
	input wire logic [LEN-1:0] cap_data,
	input wire logic tdi,
	output logic [LEN-1:0] sh_q,
	output logic [LEN-1:0] upd_q
);
	import jbs_pkg::*;

	logic [LEN-1:0] chain_in;

	// The top cell sits next to the data input, cell 0 next to the data output.
	assign chain_in = {tdi, sh_q[LEN-1:1]};

	genvar i;
	generate
		for (i = 0; i < LEN; i++) begin : g_cell
			always_ff @(posedge clk) begin
				if (rst) begin
					sh_q[i] <= 1'b0;
					upd_q[i] <= 1'b0;
				end else begin
					if (cap_en) begin
						sh_q[i] <= cap_data[i];
					end else if (shift_en) begin
						sh_q[i] <= chain_in[i];
					end
					if (upd_en) begin
						upd_q[i] <= sh_q[i]; // R5
					end
				end
			end
		end
	endgenerate

	a_update_latch: assert property (@(posedge clk) disable iff (rst) // R5
		upd_en |=> upd_q == $past(sh_q)) else $error("Update stage did not take the shift stage.");

endmodule // jbs_bsr

// ### tb/jbs_tester.sv
// Board tester model that drives the four test input pins and reads the data output.
`timescale 1ns/1ps
module jbs_tester (
	input wire logic clk,
	input wire logic tdo,
	input wire logic tdo_oe,
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_n
);
	logic last_r;
	logic tdo_line;
	// A released data out line flips, so a stale level is never read as data.
	assign tdo_line = tdo_oe ? tdo : ~last_r;
	always @(posedge clk) begin
		if (tdo_oe) begin
			last_r <= tdo;
		end
	end
	initial begin
		last_r = 1'b0;
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trst_n = 1'b0;
	end
	// The test clock idles low between calls; each phase spans several system clocks.
	task automatic step(input logic m, input logic d, output logic q);
		@(posedge clk);
		#1;
		tms = m;
		tdi = d;
		repeat (4) @(posedge clk);
		#1;
		tck = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		q = tdo_line;
		tck = 1'b0;
	endtask
	task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
		logic q;
		dout = '0;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask
	task automatic scan_ir(input logic [3:0] op, output logic [3:0] cap);
		logic q;
		logic [31:0] w;
		step(1'b1, 1'b0, q);
		step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
		step(1'b0, 1'b0, q);
		shift(4, {28'h0, op}, w);
		cap = w[3:0];
	endtask
	task automatic scan_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
		logic q;
		step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
		step(1'b0, 1'b0, q);
		shift(n, din, dout);
	endtask
	task automatic pulse_reset();
		@(posedge clk);
		#1;
		trst_n = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		trst_n = 1'b1;
		repeat (6) @(posedge clk);
	endtask
	task automatic go_idle();
		logic q;
		for (int i = 0; i < 5; i++) begin
			step(1'b1, 1'b0, q);
		end
		step(1'b0, 1'b0, q);
	endtask
endmodule // jbs_tester

// ### tb/jtag_boundary_scan_tap_tb_top.sv
// Self-checking bench for the test access port driven by the tester model.
`timescale 1ns/1ps
module jtag_boundary_scan_tap_tb_top;
	import jbs_pkg::*;
	localparam logic [31:0] ID_EXP = {4'h3, 16'h0a5c, 11'h02b, 1'b1};
	logic clk, rst, tck, tms, tdi, trst_n, tdo, tdo_oe, factory_test, q;
	logic [7:0] pin_in, core_in, core_out, pin_out;
	logic [31:0] dout;
	logic [3:0] cap;
	int failures;
	int check_count;
	// Identity values are arbitrary.
	jbs_tap #(.ID_VERSION(4'h3), .ID_PART(16'h0a5c), .ID_MFR(11'h02b)) u_dut (.clk(clk), .rst(rst), .tck(tck),
		.tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .core_in(core_in),
		.core_out(core_out), .pin_out(pin_out), .factory_test(factory_test));
	jbs_tester u_tester (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));
	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		chk_word(what, {31'h0, exp}, {31'h0, got});
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic t_idcode();
		u_tester.go_idle();
		chk_bit("oe idle", 1'b0, tdo_oe);
		u_tester.scan_dr(32, 32'h0, dout);
		chk_word("idcode", ID_EXP, dout);
		chk_bit("id lsb", 1'b1, dout[0]);
	endtask
	task automatic t_bypass();
		jbs_ir_t ops[3] = '{JBS_OP_BYPASS, 4'h5, JBS_OP_PRIVATE_FACTORY_TEST};
		foreach (ops[i]) begin
			u_tester.scan_ir(ops[i], cap);
			chk_word("ir capture", 32'h1, {28'h0, cap});
			chk_bit("factory", ops[i] == 4'h8, factory_test);
			u_tester.scan_dr(8, 32'hb5, dout);
			chk_word("bypass path", 32'h6a, dout);
		end
	endtask
	task automatic t_sample_extest();
		u_tester.scan_ir(JBS_OP_SAMPLE, cap);
		chk_word("pins sample", 32'h3c, {24'h0, pin_out});
		u_tester.scan_dr(16, 32'h9600, dout);
		chk_word("sample capture", 32'h3ca5, dout);
		chk_word("pins preload", 32'h3c, {24'h0, pin_out});
		u_tester.scan_ir(JBS_OP_EXTEST, cap);
		chk_word("extest drive", 32'h96, {24'h0, pin_out});
		pin_in = 8'h5a;
		u_tester.scan_dr(16, 32'h6900, dout);
		chk_word("extest observe", 32'h5a, {24'h0, dout[7:0]});
		chk_word("extest update", 32'h69, {24'h0, pin_out});
	endtask
	task automatic t_clamp();
		u_tester.scan_ir(JBS_OP_CLAMP, cap);
		core_out = 8'hff;
		u_tester.scan_dr(8, 32'h0f, dout);
		chk_word("clamp path", 32'h1e, dout);
		chk_word("clamp pins", 32'h69, {24'h0, pin_out});
	endtask
	task automatic t_intest();
		u_tester.scan_ir(JBS_OP_SAMPLE, cap);
		chk_word("core in", 32'h5a, {24'h0, core_in});
		u_tester.scan_dr(16, 32'h00c3, dout);
		u_tester.scan_ir(JBS_OP_INTEST, cap);
		chk_word("intest drive", 32'hc3, {24'h0, core_in});
	endtask
	task automatic t_resets();
		u_tester.scan_ir(JBS_OP_BYPASS, cap);
		u_tester.step(1'b1, 1'b0, q);
		u_tester.step(1'b0, 1'b0, q);
		u_tester.step(1'b0, 1'b0, q);
		u_tester.step(1'b0, 1'b1, q);
		chk_bit("oe shift", 1'b1, tdo_oe);
		// No test clock edge while the test reset is low.
		u_tester.pulse_reset();
		chk_bit("oe trst", 1'b0, tdo_oe);
		u_tester.step(1'b0, 1'b0, q);
		u_tester.scan_dr(32, 32'h0, dout);
		chk_word("id after trst", ID_EXP, dout);
		u_tester.scan_ir(JBS_OP_BYPASS, cap);
		u_tester.go_idle();
		u_tester.scan_dr(32, 32'h0, dout);
		chk_word("id after tms", ID_EXP, dout);
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		// The whole run needs about 0.31 ms; this leaves ample margin.
		#3000000;
		failures++;
		$display("BAD watchdog expected done seen hang");
		conclude();
	end
	initial begin
		rst = 1'b1;
		pin_in = 8'ha5;
		core_out = 8'h3c;
		failures = 0;
		check_count = 0;
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		u_tester.pulse_reset();
		t_idcode();
		t_bypass();
		t_sample_extest();
		t_clamp();
		t_intest();
		t_resets();
		conclude();
	end
endmodule // jtag_boundary_scan_tap_tb_top
